// File: logic/aps_map.svh
`ifndef APS_MAP_SVH
`define APS_MAP_SVH
// Summary of operation
// - frequency select bit 14 resets to 0; software keeps 0 for 45-55 Hz lines.
// - nominal voltage level is 28-bit signed, zero padded to 32 bits.
// - fundamental results settle within 375 ms at 63% and 875 ms at full power.
// - after a frequency select change results need 10 s before calibrating.
// - each phase has a 24-bit gain scaling its power by plus or minus 100%.
// - phase gain applies to total, fundamental, reactive and apparent power paths.
// - output is input times one plus gain over 2^23, two's complement.
// - gain and offset read as 32-bit words, top four zero, sign-extended to 28.
// - separate signed 24-bit total and fundamental offsets, one LSB per LSB.
// - full-scale in-phase inputs give a power reference of 27,059,678.
// - sign checked at each first-stage threshold crossing; a change raises an event.
// - sign source bit 6 defaults 0 for total power, 1 selects fundamental.
// - status bits 8, 7, 6 set on sign change of phases C, B, A.
// - phase sign bits 2:0 update with status bits; 1 means negative power.
// - enabled mask bits 8:6 drive the active-low interrupt low on an event.
// - writing 1 to a status bit clears it unless an event sets it that cycle; the interrupt releases once no enabled bit is set.
// - threshold is the 8-bit threshold value followed by 27 zero bits.

// register byte offsets
`define APS_ADDR_COMP    8'h00
`define APS_ADDR_ACCM    8'h04
`define APS_ADDR_NOMINAL_VOLTAGE_LEVEL  8'h08
`define APS_ADDR_GAIN0   8'h0C
`define APS_ADDR_TOS0    8'h18
`define APS_ADDR_FOS0    8'h24
`define APS_ADDR_ENERGY_THRESHOLD    8'h30
`define APS_ADDR_STATUS  8'h34
`define APS_ADDR_MASK    8'h38
`define APS_ADDR_PHASE_SIGN_FLAGS  8'h3C
`define APS_ADDR_SETTLE  8'h40
// field positions and reset values
`define APS_FREQ_SEL_BIT 14
`define APS_SRC_SEL_BIT  6
`define APS_EVT_LSB      6
`define APS_EVT_MSB      8
`define APS_ENERGY_THRESHOLD_RESET   8'h03
`define APS_THR_ZEROS    27
`define APS_GAIN_FRAC    23
`define APS_FULL_SCALE_POWER_REF         27059678
`define APS_LIGHT_PCT    63
// timing
`define APS_CLK_PERIOD_NS   10
`define APS_FREQ_SETTLE_MS  10000
`define APS_FULL_SETTLE_MS  875
`define APS_LIGHT_SETTLE_MS 375
`define APS_MS_CYC(ms) ((ms) * (1000000 / `APS_CLK_PERIOD_NS))
`endif

// File: logic/aps_pkg.sv
package aps_pkg;
  // one phase worth of filtered powers, 28-bit datapath
  typedef struct packed {
    logic signed [27:0] total;
    logic signed [27:0] fund;
    logic signed [27:0] react;
    logic signed [27:0] appar;
  } aps_power_s;

  // read access sequencing of the bus slave
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_RLOAD = 3'b010,
    BUS_RDONE = 3'b100
  } aps_bus_e;
endpackage : aps_pkg

// File: logic/aps_active_power.sv
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "aps_map.svh"
module aps_active_power #(
  parameter int unsigned FREQ_SETTLE_CYC  = `APS_MS_CYC(`APS_FREQ_SETTLE_MS),
  parameter int unsigned FULL_SETTLE_CYC  = `APS_MS_CYC(`APS_FULL_SETTLE_MS),
  parameter int unsigned LIGHT_SETTLE_CYC = `APS_MS_CYC(`APS_LIGHT_SETTLE_MS),
  parameter int          ACC_W            = 38
) (
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  input  wire aps_pkg::aps_power_s [2:0]    powerIn,
  input  wire logic                         powerValid,
  input  wire logic                         accTick,
  output aps_pkg::aps_power_s [2:0]         powerOut,
  output logic [5:0]                        energyPulse,
  output logic                              netFreqSelect,
  output logic                              fundSettled,
  output logic                              interruptOutN
);

  // saturate a 29-bit intermediate back to the 28-bit datapath
  function automatic logic signed [27:0] sat28(input logic signed [28:0] v);
    if (v[28] != v[27])
      sat28 = v[28] ? {1'b1, 27'h0000000} : {1'b0, {27{1'b1}}};
    else
      sat28 = v[27:0];
  endfunction : sat28

  // p * (1 + g / 2^23)
  function automatic logic signed [27:0] applyGain(input logic signed [27:0] p,
                                                   input logic signed [23:0] g);
    logic signed [51:0] prod;
    logic signed [28:0] sum;
    prod = 52'(p * g);
    sum  = $signed({p[27], p}) + $signed(prod[51:`APS_GAIN_FRAC]);
    applyGain = sat28(sum);
  endfunction : applyGain

  // add a 24-bit signed offset in multiplier LSBs
  function automatic logic signed [27:0] addOffset(input logic signed [27:0] p,
                                                   input logic signed [23:0] os);
    logic signed [28:0] sum;
    sum = $signed({p[27], p}) + $signed({{5{os[23]}}, os});
    addOffset = sat28(sum);
  endfunction : addOffset

  // register read view: 24-bit value sign-extended to 28, top nibble zero
  function automatic logic [31:0] sext24(input logic [23:0] v);
    sext24 = {4'h0, {4{v[23]}}, v};
  endfunction : sext24

  aps_pkg::aps_bus_e        busSt_q;
  logic [7:0]               addr_q;
  logic                     wrPend_q;
  logic                     freqSel_q;
  logic                     srcSel_q;
  logic [27:0]              nominal_voltage_level_q;
  logic [23:0]              gain_q  [3];
  logic [23:0]              tos_q   [3];
  logic [23:0]              fos_q   [3];
  logic [7:0]               energy_threshold_q;
  logic [2:0]               status_q;
  logic [2:0]               mask_q;
  logic [2:0]               phaseSign_q;
  logic [31:0]              settle_q;
  logic signed [ACC_W-1:0]  acc_q   [6];
  logic [5:0]               pulsePos;
  logic [5:0]               pulseNeg;
  logic signed [ACC_W-1:0]  accNext [6];
  logic signed [ACC_W-1:0]  thr;
  logic [2:0]               signEvt;
  logic [2:0]               newSign;
  logic [2:0]               statusClr;
  logic                     addrTake;
  logic                     wrEn;
  logic [31:0]              readMux;
  logic                     heavyLoad;

  assign addrTake = hsel & htrans[1] & hready;
  assign wrEn     = wrPend_q;
  assign hresp    = 1'b0;
  // reads take one wait state so a write just before is always seen
  assign hreadyout = (busSt_q != aps_pkg::BUS_RLOAD);
  assign netFreqSelect = freqSel_q;
  assign fundSettled   = (settle_q == 32'h0000_0000);

  // bus sequencing
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busSt_q  <= aps_pkg::BUS_IDLE;
      addr_q   <= 8'h00;
      wrPend_q <= 1'b0;
    end
    else
    begin
      unique case (busSt_q)
        aps_pkg::BUS_IDLE,
        aps_pkg::BUS_RDONE: busSt_q <= (addrTake & ~hwrite) ? aps_pkg::BUS_RLOAD
                                                             : aps_pkg::BUS_IDLE;
        aps_pkg::BUS_RLOAD: busSt_q <= aps_pkg::BUS_RDONE;
      endcase
      if (addrTake)
        addr_q <= {haddr[7:2], 2'b00};
      wrPend_q <= addrTake & hwrite;
    end
  end

  // read multiplexer; unmapped words read zero
  always_comb
  begin
    readMux = 32'h0000_0000;
    unique case (addr_q)
      `APS_ADDR_COMP:   readMux[`APS_FREQ_SEL_BIT] = freqSel_q;
      `APS_ADDR_ACCM:   readMux[`APS_SRC_SEL_BIT] = srcSel_q;
      `APS_ADDR_NOMINAL_VOLTAGE_LEVEL: readMux = {4'h0, nominal_voltage_level_q};
      `APS_ADDR_GAIN0:  readMux = sext24(gain_q[0]);
      8'h10:            readMux = sext24(gain_q[1]);
      8'h14:            readMux = sext24(gain_q[2]);
      `APS_ADDR_TOS0:   readMux = sext24(tos_q[0]);
      8'h1C:            readMux = sext24(tos_q[1]);
      8'h20:            readMux = sext24(tos_q[2]);
      `APS_ADDR_FOS0:   readMux = sext24(fos_q[0]);
      8'h28:            readMux = sext24(fos_q[1]);
      8'h2C:            readMux = sext24(fos_q[2]);
      `APS_ADDR_ENERGY_THRESHOLD:   readMux[7:0] = energy_threshold_q;
      `APS_ADDR_STATUS: readMux[`APS_EVT_MSB:`APS_EVT_LSB] = status_q;
      `APS_ADDR_MASK:   readMux[`APS_EVT_MSB:`APS_EVT_LSB] = mask_q;
      `APS_ADDR_PHASE_SIGN_FLAGS: readMux[2:0] = phaseSign_q;
      `APS_ADDR_SETTLE: readMux[0] = fundSettled;
      default:          readMux = 32'h0000_0000;
    endcase
  end

  // read data is loaded during the wait state and held until the next read
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (busSt_q == aps_pkg::BUS_RLOAD)
      hrdata <= readMux;
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      freqSel_q <= 1'b0;
      srcSel_q  <= 1'b0;
      nominal_voltage_level_q  <= 28'h0000000;
      energy_threshold_q    <= `APS_ENERGY_THRESHOLD_RESET;
      mask_q    <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        gain_q[i] <= 24'h000000;
        tos_q[i]  <= 24'h000000;
        fos_q[i]  <= 24'h000000;
      end
    end
    else if (wrEn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (addr_q == 8'(`APS_ADDR_GAIN0 + 4 * i))
          gain_q[i] <= hwdata[23:0];
        if (addr_q == 8'(`APS_ADDR_TOS0 + 4 * i))
          tos_q[i] <= hwdata[23:0];
        if (addr_q == 8'(`APS_ADDR_FOS0 + 4 * i))
          fos_q[i] <= hwdata[23:0];
      end
      unique case (addr_q)
        `APS_ADDR_COMP:   freqSel_q <= hwdata[`APS_FREQ_SEL_BIT];
        `APS_ADDR_ACCM:   srcSel_q <= hwdata[`APS_SRC_SEL_BIT];
        `APS_ADDR_NOMINAL_VOLTAGE_LEVEL: nominal_voltage_level_q <= hwdata[27:0];
        `APS_ADDR_ENERGY_THRESHOLD:   energy_threshold_q <= hwdata[7:0];
        `APS_ADDR_MASK:   mask_q <= hwdata[`APS_EVT_MSB:`APS_EVT_LSB];
        default:          ;
      endcase
    end
  end

  // heavy load when any fundamental power exceeds 63% of the reference
  always_comb
  begin
    heavyLoad = 1'b0;
    for (int i = 0; i < 3; i++)
      if ((powerOut[i].fund > 28'sd0 ? powerOut[i].fund : -powerOut[i].fund) >
          28'sd`APS_FULL_SCALE_POWER_REF * `APS_LIGHT_PCT / 100)
        heavyLoad = 1'b1;
  end

  // settling timer: a frequency select change costs the long wait, a new
  // nominal level the load-dependent one; results are flagged unsettled meanwhile
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      settle_q <= 32'h0000_0000;
    else if (wrEn && addr_q == `APS_ADDR_COMP && hwdata[`APS_FREQ_SEL_BIT] != freqSel_q)
      settle_q <= FREQ_SETTLE_CYC;
    else if (wrEn && addr_q == `APS_ADDR_NOMINAL_VOLTAGE_LEVEL)
      settle_q <= heavyLoad ? FULL_SETTLE_CYC : LIGHT_SETTLE_CYC;
    else if (settle_q != 32'h0000_0000)
      settle_q <= settle_q - 32'h0000_0001;
  end

  // gain on every path, offsets on the two active paths
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      powerOut <= '0;
    else if (powerValid)
    begin
      for (int i = 0; i < 3; i++)
      begin
        powerOut[i].total <= addOffset(applyGain(powerIn[i].total, gain_q[i]), tos_q[i]);
        powerOut[i].fund  <= addOffset(applyGain(powerIn[i].fund, gain_q[i]), fos_q[i]);
        powerOut[i].react <= applyGain(powerIn[i].react, gain_q[i]);
        powerOut[i].appar <= applyGain(powerIn[i].appar, gain_q[i]);
      end
    end
  end

  // first-stage threshold crossing per path; path 2*phase is total, 2*phase+1 fund
  assign thr = ACC_W'({energy_threshold_q, {`APS_THR_ZEROS{1'b0}}});
  always_comb
  begin
    for (int k = 0; k < 6; k++)
    begin
      accNext[k]  = acc_q[k] + ACC_W'(k[0] ? powerOut[k / 2].fund : powerOut[k / 2].total);
      pulsePos[k] = accTick && (accNext[k] >= thr);
      pulseNeg[k] = accTick && !pulsePos[k] && (accNext[k] <= -thr);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < 6; k++)
        acc_q[k] <= '0;
      energyPulse <= 6'h00;
    end
    else
    begin
      for (int k = 0; k < 6; k++)
        if (accTick)
          acc_q[k] <= pulsePos[k] ? accNext[k] - thr :
                      pulseNeg[k] ? accNext[k] + thr : accNext[k];
      energyPulse <= pulsePos | pulseNeg;
    end
  end

  // sign change on the selected source at a crossing
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      newSign[i] = pulseNeg[2 * i + int'(srcSel_q)];
      signEvt[i] = (pulsePos[2 * i + int'(srcSel_q)] | newSign[i]) &&
                   (newSign[i] != phaseSign_q[i]);
    end
  end

  assign statusClr = (wrEn && addr_q == `APS_ADDR_STATUS) ?
                     hwdata[`APS_EVT_MSB:`APS_EVT_LSB] : 3'h0;

  // status and sign; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q    <= 3'h0;
      phaseSign_q <= 3'h0;
    end
    else
    begin
      status_q <= (status_q & ~statusClr) | signEvt;
      for (int i = 0; i < 3; i++)
        if (signEvt[i])
          phaseSign_q[i] <= newSign[i];
    end
  end

  // interrupt low while any enabled flag is set, registered to avoid glitches
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      interruptOutN <= 1'b1;
    else
      interruptOutN <= ~|(status_q & mask_q);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_freq_sel_default: assert property (disable iff (1'b0) sys_rst |=> !freqSel_q)
    else $error("frequency select not zero after reset");
  a_nominal_voltage_level_pad: assert property ($rose(hreadyout) && addr_q == `APS_ADDR_NOMINAL_VOLTAGE_LEVEL
    |-> hrdata[31:28] == 4'h0)
    else $error("nominal level read not zero padded");
  a_gain_read_ext: assert property ($rose(hreadyout) && addr_q == `APS_ADDR_GAIN0
    |-> hrdata[31:28] == 4'h0 && hrdata[27:24] == {4{hrdata[23]}})
    else $error("gain read not sign extended");
  a_gain_unity: assert property (powerValid && gain_q[0] == 24'h0 && tos_q[0] == 24'h0
    |=> powerOut[0].total == $past(powerIn[0].total))
    else $error("zero gain changed power");
  a_gain_half: assert property (powerValid && gain_q[1] == 24'hC00000
    |=> powerOut[1].react == $past(powerIn[1].react) >>> 1)
    else $error("negative half gain wrong");
  a_offset_add: assert property (powerValid && gain_q[2] == 24'h0 && fos_q[2] == 24'h000001
    && powerIn[2].fund == 28'sd100 |=> powerOut[2].fund == 28'sd101)
    else $error("offset lsb not one lsb");
  a_sign_with_flag: assert property ($rose(status_q[0]) |-> $changed(phaseSign_q[0]))
    else $error("sign bit not updated with flag");
  a_flag_cause: assert property ($rose(status_q[1])
    |-> $past(pulsePos[2 + int'(srcSel_q)] | pulseNeg[2 + int'(srcSel_q)]))
    else $error("flag set without crossing");
  a_irq_low: assert property (|(status_q & mask_q) |=> !interruptOutN)
    else $error("interrupt not asserted");
  a_irq_release: assert property (!(|(status_q & mask_q)) |=> interruptOutN [*1])
    else $error("interrupt held without flag");
  a_flag_clear: assert property (statusClr[2] && !signEvt[2] |=> !status_q[2])
    else $error("write one did not clear flag");
  a_settle_hold: assert property (wrEn && addr_q == `APS_ADDR_COMP
    && hwdata[`APS_FREQ_SEL_BIT] != freqSel_q |=> !fundSettled [*8])
    else $error("settled too soon after frequency change");

  c_sign_event: cover property ($rose(status_q[0]));
  c_irq_cycle: cover property (!interruptOutN ##[1:50] interruptOutN);
  c_set_and_clear: cover property (statusClr[0] && signEvt[0]);

endmodule : aps_active_power

// File: testbench/aps_active_power_tb_top.sv
`timescale 1ns/10ps
`include "aps_map.svh"
module aps_active_power_tb_top;
  logic                      clk_sys;
  logic                      sys_rst;
  logic                      hsel;
  logic [31:0]               haddr;
  logic [1:0]                htrans;
  logic                      hwrite;
  logic [2:0]                hsize;
  logic [31:0]               hwdata;
  wire logic                 hready;
  logic                      hreadyout;
  logic                      hresp;
  logic [31:0]               hrdata;
  aps_pkg::aps_power_s [2:0] powerIn;
  logic                      powerValid;
  logic                      accTick;
  aps_pkg::aps_power_s [2:0] powerOut;
  logic [5:0]                energyPulse;
  logic                      netFreqSelect;
  logic                      fundSettled;
  logic                      interruptOutN;
  logic [31:0]               rd;
  logic [5:0]                pulseSeen;
  int                        failCount;
  int                        checksDone;
  int                        n;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  aps_active_power #(
    .FREQ_SETTLE_CYC  (40),
    .FULL_SETTLE_CYC  (20),
    .LIGHT_SETTLE_CYC (10),
    .ACC_W            (38)
  ) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerIn(powerIn),
    .powerValid(powerValid), .accTick(accTick), .powerOut(powerOut),
    .energyPulse(energyPulse), .netFreqSelect(netFreqSelect),
    .fundSettled(fundSettled), .interruptOutN(interruptOutN)
  );

  // free running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  task summarize;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is looked at mid cycle, so the edge that follows is the one that takes it
  task waitRdy;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50)
    begin
      failCount++;
      $display("MISMATCH at %0t: bus never ready", $time);
      summarize();
    end
    @(posedge clk_sys);
  endtask : waitRdy

  task busOp(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask : busOp

  task bw(input logic [7:0] a, input logic [31:0] d);
    busOp(a, 1'b1, d);
  endtask : bw

  task br(input logic [7:0] a, input logic [31:0] exp);
    busOp(a, 1'b0, 32'h00000000);
    chk(rd, exp);
  endtask : br

  // same total on the reactive and apparent paths of each phase
  task setp(input logic signed [27:0] ta, tb, tc, fa, fb, fc);
    @(posedge clk_sys);
    powerIn    <= {{tc, fc, tc, tc}, {tb, fb, tb, tb}, {ta, fa, ta, ta}};
    powerValid <= 1'b1;
    @(posedge clk_sys);
    powerValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : setp

  task tick;
    @(posedge clk_sys);
    accTick <= 1'b1;
    @(posedge clk_sys);
    accTick <= 1'b0;
    // the crossing pulse stands only in the cycle after the tick edge
    @(negedge clk_sys);
    pulseSeen = energyPulse;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : tick

  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    powerIn = '0;
    powerValid = 1'b0;
    accTick = 1'b0;
    failCount = 0;
    checksDone = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset values and unmapped place
    br(`APS_ADDR_COMP, 32'h00000000);
    br(`APS_ADDR_ACCM, 32'h00000000);
    br(`APS_ADDR_ENERGY_THRESHOLD, 32'h00000003);
    br(`APS_ADDR_STATUS, 32'h00000000);
    br(8'h80, 32'h00000000);
    chk({31'h0, interruptOutN}, 32'h00000001);
    chk({31'h0, netFreqSelect | hresp}, 32'h00000000);
    // gain of plus one half on every path, minus one half on the total and apparent paths
    bw(`APS_ADDR_GAIN0, 32'h00400000);
    setp(28'sd1000, 28'sd0, 28'sd0, 28'sd2000, 28'sd0, 28'sd0);
    chk(32'(powerOut[0].total), 32'd1500);
    chk(32'(powerOut[0].fund), 32'd3000);
    chk(32'(powerOut[0].react), 32'd1500);
    chk(32'(powerOut[0].appar), 32'd1500);
    bw(`APS_ADDR_GAIN0, 32'h00C00000);
    br(`APS_ADDR_GAIN0, 32'h0FC00000);
    setp(28'sd1000, 28'sd0, 28'sd0, 28'sd2000, 28'sd0, 28'sd0);
    chk(32'(powerOut[0].total), 32'd500);
    chk(32'(powerOut[0].appar), 32'd500);
    bw(`APS_ADDR_GAIN0, 32'h00000000);
    // total and fundamental offsets are separate
    bw(`APS_ADDR_TOS0, 32'h00000005);
    bw(`APS_ADDR_FOS0, 32'h00FFFFFF);
    br(`APS_ADDR_FOS0, 32'h0FFFFFFF);
    setp(28'sd1000, 28'sd0, 28'sd0, 28'sd2000, 28'sd0, 28'sd0);
    chk(32'(powerOut[0].total), 32'd1005);
    chk(32'(powerOut[0].fund), 32'd1999);
    chk(32'(powerOut[0].react), 32'd1000);
    bw(`APS_ADDR_TOS0, 32'h00000000);
    bw(`APS_ADDR_FOS0, 32'h00000000);
    // nominal level keeps 28 bits
    bw(`APS_ADDR_NOMINAL_VOLTAGE_LEVEL, 32'hFFFFFFFF);
    br(`APS_ADDR_NOMINAL_VOLTAGE_LEVEL, 32'h0FFFFFFF);
    repeat (30) @(posedge clk_sys);
    // a frequency select change starts the long settle count
    bw(`APS_ADDR_COMP, 32'h00004000);
    br(`APS_ADDR_COMP, 32'h00004000);
    chk({30'h0, netFreqSelect, fundSettled}, 32'h00000002);
    n = 0;
    while (fundSettled !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({31'h0, n >= 25 && n <= 40}, 32'h00000001);
    // smallest threshold, two ticks needed to cross it
    bw(`APS_ADDR_ENERGY_THRESHOLD, 32'h00000001);
    bw(`APS_ADDR_MASK, 32'h000001C0);
    setp(-28'sd67108864, -28'sd67108864, 28'sd67108864, 28'sd0, 28'sd0, 28'sd0);
    tick();
    chk({31'h0, interruptOutN}, 32'h00000001);
    chk({26'h0, pulseSeen}, 32'h00000000);
    tick();
    chk({31'h0, interruptOutN}, 32'h00000000);
    chk({26'h0, pulseSeen}, 32'h00000015);
    br(`APS_ADDR_STATUS, 32'h000000C0);
    br(`APS_ADDR_PHASE_SIGN_FLAGS, 32'h00000003);
    bw(`APS_ADDR_STATUS, 32'h00000040);
    br(`APS_ADDR_STATUS, 32'h00000080);
    chk({31'h0, interruptOutN}, 32'h00000000);
    bw(`APS_ADDR_STATUS, 32'h00000080);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, interruptOutN}, 32'h00000001);
    // fundamental source, masked event leaves the pin high
    bw(`APS_ADDR_MASK, 32'h00000000);
    bw(`APS_ADDR_ACCM, 32'h00000040);
    setp(28'sd0, 28'sd0, 28'sd0, 28'sd0, 28'sd0, -28'sd134217728);
    tick();
    chk({26'h0, pulseSeen}, 32'h00000020);
    br(`APS_ADDR_STATUS, 32'h00000100);
    br(`APS_ADDR_PHASE_SIGN_FLAGS, 32'h00000007);
    chk({31'h0, interruptOutN}, 32'h00000001);
    summarize();
  end
endmodule : aps_active_power_tb_top
